// >>> logic/iep_edge_detect.sv
// Rising and falling edge detector for one synchronous digital input.
`timescale 1ns/1ps
module iep_edge_detect
  import iep_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic level,
  output logic rise,
  output logic fall
);

  logic prev_r;
  logic prev_nxt;
  logic armed_r;
  logic armed_nxt;

  always_comb
  begin
    prev_nxt = level;
    armed_nxt = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      prev_r <= 1'b0;
      armed_r <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      armed_r <= armed_nxt;
    end
  end

  // The first sample after reset only loads history, so a high input is not an edge.
  assign rise = armed_r & level & ~prev_r;
  assign fall = armed_r & ~level & prev_r;

endmodule : iep_edge_detect

// >>> logic/iep_pend_flag.sv
// Sticky pending flag with overrun tracking for one interrupt event.
`timescale 1ns/1ps
module iep_pend_flag
  import iep_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic raise,
  input wire logic clear,
  input wire logic overrun_clear,
  output logic pending,
  output logic overrun
);

  logic pend_r;
  logic pend_nxt;
  logic ovr_r;
  logic ovr_nxt;

  // A raise in the clearing cycle wins, so no event is lost.
  always_comb
  begin
    pend_nxt = raise | (pend_r & ~clear);
    ovr_nxt = (raise & pend_r & ~clear) | (ovr_r & ~overrun_clear);
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pend_r <= 1'b0;
      ovr_r <= 1'b0;
    end
    else
    begin
      pend_r <= pend_nxt;
      ovr_r <= ovr_nxt;
    end
  end

  assign pending = pend_r;
  assign overrun = ovr_r;

endmodule : iep_pend_flag

// >>> logic/iep_pkg.sv
// Package with event numbers, priority table and carrier types of the event prioritizer.
package iep_pkg;

  localparam int IEP_EVENT_COUNT = 34;
  localparam int IEP_NUM_W = 6;
  localparam int IEP_RANK_W = 5;
  localparam int IEP_DIN_COUNT = 4;

  // Priority groups, highest first.
  localparam logic [1:0] IEP_GRP_COMM = 2'h0;
  localparam logic [1:0] IEP_GRP_DISCRETE = 2'h1;
  localparam logic [1:0] IEP_GRP_TIMED = 2'h2;

  // Event numbers.
  localparam logic [5:0] IEP_EV_DIN_BASE = 6'h00;
  localparam logic [5:0] IEP_EV_P0_RX_CHAR = 6'h08;
  localparam logic [5:0] IEP_EV_P0_TX_DONE = 6'h09;
  localparam logic [5:0] IEP_EV_PERIODIC_0 = 6'h0a;
  localparam logic [5:0] IEP_EV_PERIODIC_1 = 6'h0b;
  localparam logic [5:0] IEP_EV_FC0_MATCH = 6'h0c;
  localparam logic [5:0] IEP_EV_FC1_MATCH = 6'h0d;
  localparam logic [5:0] IEP_EV_FC1_DIR = 6'h0e;
  localparam logic [5:0] IEP_EV_FC1_RESET = 6'h0f;
  localparam logic [5:0] IEP_EV_FC2_MATCH = 6'h10;
  localparam logic [5:0] IEP_EV_FC2_DIR = 6'h11;
  localparam logic [5:0] IEP_EV_FC2_RESET = 6'h12;
  localparam logic [5:0] IEP_EV_PULSE0_DONE = 6'h13;
  localparam logic [5:0] IEP_EV_PULSE1_DONE = 6'h14;
  localparam logic [5:0] IEP_EV_TMR_A_DONE = 6'h15;
  localparam logic [5:0] IEP_EV_TMR_B_DONE = 6'h16;
  localparam logic [5:0] IEP_EV_P0_RX_MSG = 6'h17;
  localparam logic [5:0] IEP_EV_P1_RX_MSG = 6'h18;
  localparam logic [5:0] IEP_EV_P1_RX_CHAR = 6'h19;
  localparam logic [5:0] IEP_EV_P1_TX_DONE = 6'h1a;
  localparam logic [5:0] IEP_EV_FC0_DIR = 6'h1b;
  localparam logic [5:0] IEP_EV_FC0_RESET = 6'h1c;
  localparam logic [5:0] IEP_EV_FC4_MATCH = 6'h1d;
  localparam logic [5:0] IEP_EV_FC4_DIR = 6'h1e;
  localparam logic [5:0] IEP_EV_FC4_RESET = 6'h1f;
  localparam logic [5:0] IEP_EV_FC3_MATCH = 6'h20;
  localparam logic [5:0] IEP_EV_FC5_MATCH = 6'h21;

  typedef struct packed {
    logic [5:0] number;
    logic [1:0] group;
    logic [4:0] rank;
  } iep_entry_t;

  // Table in service order; equal ranks are broken by table position.
  localparam iep_entry_t IEP_TABLE [IEP_EVENT_COUNT] = '{
    '{IEP_EV_P0_RX_CHAR, IEP_GRP_COMM, 5'h00},
    '{IEP_EV_P0_TX_DONE, IEP_GRP_COMM, 5'h00},
    '{IEP_EV_P0_RX_MSG, IEP_GRP_COMM, 5'h00},
    '{IEP_EV_P1_RX_MSG, IEP_GRP_COMM, 5'h01},
    '{IEP_EV_P1_RX_CHAR, IEP_GRP_COMM, 5'h01},
    '{IEP_EV_P1_TX_DONE, IEP_GRP_COMM, 5'h01},
    '{IEP_EV_PULSE0_DONE, IEP_GRP_DISCRETE, 5'h00},
    '{IEP_EV_PULSE1_DONE, IEP_GRP_DISCRETE, 5'h01},
    '{6'h00, IEP_GRP_DISCRETE, 5'h02},
    '{6'h02, IEP_GRP_DISCRETE, 5'h03},
    '{6'h04, IEP_GRP_DISCRETE, 5'h04},
    '{6'h06, IEP_GRP_DISCRETE, 5'h05},
    '{6'h01, IEP_GRP_DISCRETE, 5'h06},
    '{6'h03, IEP_GRP_DISCRETE, 5'h07},
    '{6'h05, IEP_GRP_DISCRETE, 5'h08},
    '{6'h07, IEP_GRP_DISCRETE, 5'h09},
    '{IEP_EV_FC0_MATCH, IEP_GRP_DISCRETE, 5'h0a},
    '{IEP_EV_FC0_DIR, IEP_GRP_DISCRETE, 5'h0b},
    '{IEP_EV_FC0_RESET, IEP_GRP_DISCRETE, 5'h0c},
    '{IEP_EV_FC1_MATCH, IEP_GRP_DISCRETE, 5'h0d},
    '{IEP_EV_FC1_DIR, IEP_GRP_DISCRETE, 5'h0e},
    '{IEP_EV_FC1_RESET, IEP_GRP_DISCRETE, 5'h0f},
    '{IEP_EV_FC2_MATCH, IEP_GRP_DISCRETE, 5'h10},
    '{IEP_EV_FC2_DIR, IEP_GRP_DISCRETE, 5'h11},
    '{IEP_EV_FC2_RESET, IEP_GRP_DISCRETE, 5'h12},
    '{IEP_EV_FC3_MATCH, IEP_GRP_DISCRETE, 5'h13},
    '{IEP_EV_FC4_MATCH, IEP_GRP_DISCRETE, 5'h14},
    '{IEP_EV_FC4_DIR, IEP_GRP_DISCRETE, 5'h15},
    '{IEP_EV_FC4_RESET, IEP_GRP_DISCRETE, 5'h16},
    '{IEP_EV_FC5_MATCH, IEP_GRP_DISCRETE, 5'h17},
    '{IEP_EV_PERIODIC_0, IEP_GRP_TIMED, 5'h00},
    '{IEP_EV_PERIODIC_1, IEP_GRP_TIMED, 5'h01},
    '{IEP_EV_TMR_A_DONE, IEP_GRP_TIMED, 5'h02},
    '{IEP_EV_TMR_B_DONE, IEP_GRP_TIMED, 5'h03}
  };

  localparam iep_entry_t IEP_GRANT_RST = '{6'h00, 2'h0, 5'h00};

  typedef struct packed {
    logic rx_char;
    logic tx_done;
    logic rx_msg;
  } iep_port_t;

  typedef struct packed {
    logic preset_match;
    logic dir_change;
    logic ext_reset;
  } iep_counter_t;

  typedef struct packed {
    iep_port_t port0;
    iep_port_t port1;
    logic [1:0] pulse_train_output_done;
    iep_counter_t fast_counter_0;
    iep_counter_t fast_counter_1;
    iep_counter_t fast_counter_2;
    logic fast_counter_3_match;
    iep_counter_t fast_counter_4;
    logic fast_counter_5_match;
    logic [1:0] periodic;
    logic ms_delay_timer_a_done;
    logic ms_delay_timer_b_done;
  } iep_sources_t;

  typedef enum logic {IEP_ST_IDLE, IEP_ST_OFFER} iep_state_t;

endpackage : iep_pkg

// >>> logic/iep_prioritizer.sv
// Interrupt event prioritizer: latches events and offers the winner to the dispatcher.
`timescale 1ns/1ps
module iep_prioritizer
  import iep_pkg::*;
#(
  parameter int EVENT_COUNT = IEP_EVENT_COUNT,
  parameter int DIN_COUNT = IEP_DIN_COUNT
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire iep_sources_t sources,
  input wire logic [DIN_COUNT-1:0] digital_in,
  input wire logic [EVENT_COUNT-1:0] event_enable,
  input wire logic global_enable,
  input wire logic flush,
  input wire logic [EVENT_COUNT-1:0] overrun_clear,
  output logic irq_valid,
  input wire logic irq_ack,
  output iep_entry_t irq_grant,
  output logic [EVENT_COUNT-1:0] pending,
  output logic [EVENT_COUNT-1:0] overrun
);

  logic [EVENT_COUNT-1:0] ev_raise;
  logic [EVENT_COUNT-1:0] ev_take;
  logic [EVENT_COUNT-1:0] ev_clear;
  logic [DIN_COUNT-1:0] din_rise;
  logic [DIN_COUNT-1:0] din_fall;
  iep_state_t state_r;
  iep_state_t state_nxt;
  iep_entry_t grant_r;
  iep_entry_t grant_nxt;
  iep_entry_t winner;
  logic winner_found;

  // Communications sources.
  always_comb
  begin
    ev_raise = '0;
    ev_raise[IEP_EV_P0_RX_CHAR] = sources.port0.rx_char;
    ev_raise[IEP_EV_P0_TX_DONE] = sources.port0.tx_done;
    ev_raise[IEP_EV_P0_RX_MSG] = sources.port0.rx_msg;
    ev_raise[IEP_EV_P1_RX_MSG] = sources.port1.rx_msg;
    ev_raise[IEP_EV_P1_RX_CHAR] = sources.port1.rx_char;
    ev_raise[IEP_EV_P1_TX_DONE] = sources.port1.tx_done;
    // Discrete sources.
    ev_raise[IEP_EV_PULSE0_DONE] = sources.pulse_train_output_done[0];
    ev_raise[IEP_EV_PULSE1_DONE] = sources.pulse_train_output_done[1];
    ev_raise[IEP_EV_FC0_MATCH] = sources.fast_counter_0.preset_match;
    ev_raise[IEP_EV_FC0_DIR] = sources.fast_counter_0.dir_change;
    ev_raise[IEP_EV_FC0_RESET] = sources.fast_counter_0.ext_reset;
    ev_raise[IEP_EV_FC1_MATCH] = sources.fast_counter_1.preset_match;
    ev_raise[IEP_EV_FC1_DIR] = sources.fast_counter_1.dir_change;
    ev_raise[IEP_EV_FC1_RESET] = sources.fast_counter_1.ext_reset;
    ev_raise[IEP_EV_FC2_MATCH] = sources.fast_counter_2.preset_match;
    ev_raise[IEP_EV_FC2_DIR] = sources.fast_counter_2.dir_change;
    ev_raise[IEP_EV_FC2_RESET] = sources.fast_counter_2.ext_reset;
    ev_raise[IEP_EV_FC3_MATCH] = sources.fast_counter_3_match;
    ev_raise[IEP_EV_FC4_MATCH] = sources.fast_counter_4.preset_match;
    ev_raise[IEP_EV_FC4_DIR] = sources.fast_counter_4.dir_change;
    ev_raise[IEP_EV_FC4_RESET] = sources.fast_counter_4.ext_reset;
    ev_raise[IEP_EV_FC5_MATCH] = sources.fast_counter_5_match;
    // Timed sources.
    ev_raise[IEP_EV_PERIODIC_0] = sources.periodic[0];
    ev_raise[IEP_EV_PERIODIC_1] = sources.periodic[1];
    ev_raise[IEP_EV_TMR_A_DONE] = sources.ms_delay_timer_a_done;
    ev_raise[IEP_EV_TMR_B_DONE] = sources.ms_delay_timer_b_done;
    // Digital input edges: rising is the even number, falling the odd one.
    for (int k = 0; k < DIN_COUNT; k++)
    begin
      ev_raise[IEP_EV_DIN_BASE + 6'(2 * k)] = din_rise[k];
      ev_raise[IEP_EV_DIN_BASE + 6'(2 * k + 1)] = din_fall[k];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DIN_COUNT; gi++)
    begin : g_din
      iep_edge_detect u_edge (
        .clk(clk),
        .resetn(resetn),
        .level(digital_in[gi]),
        .rise(din_rise[gi]),
        .fall(din_fall[gi])
      );
    end
  endgenerate

  // Detached events are dropped at the door rather than queued behind the mask.
  assign ev_take = ev_raise & event_enable;

  // The offered event is retired on acknowledge; flush empties every pending flag at once.
  always_comb
  begin
    ev_clear = {EVENT_COUNT{flush}};
    if ((state_r == IEP_ST_OFFER) && irq_ack)
    begin
      ev_clear[grant_r.number] = 1'b1;
    end
  end

  generate
    for (gi = 0; gi < EVENT_COUNT; gi++)
    begin : g_pend
      iep_pend_flag u_flag (
        .clk(clk),
        .resetn(resetn),
        .raise(ev_take[gi]),
        .clear(ev_clear[gi]),
        .overrun_clear(overrun_clear[gi]),
        .pending(pending[gi]),
        .overrun(overrun[gi])
      );
    end
  endgenerate

  // Walking the table in service order gives group first, then rank.
  always_comb
  begin
    winner = IEP_GRANT_RST;
    winner_found = 1'b0;
    for (int i = 0; i < IEP_EVENT_COUNT; i++)
    begin
      if (!winner_found && pending[IEP_TABLE[i].number])
      begin
        winner = IEP_TABLE[i];
        winner_found = 1'b1;
      end
    end
  end

  // A winner is frozen while offered; a later higher event waits for the next offer.
  always_comb
  begin
    state_nxt = state_r;
    grant_nxt = grant_r;
    case (state_r)
      IEP_ST_IDLE:
      begin
        if (global_enable && winner_found && !flush)
        begin
          grant_nxt = winner;
          state_nxt = IEP_ST_OFFER;
        end
      end
      IEP_ST_OFFER:
      begin
        if (irq_ack || flush)
        begin
          state_nxt = IEP_ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = IEP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_r <= IEP_ST_IDLE;
      grant_r <= IEP_GRANT_RST;
    end
    else
    begin
      state_r <= state_nxt;
      grant_r <= grant_nxt;
    end
  end

  assign irq_valid = (state_r == IEP_ST_OFFER);
  assign irq_grant = grant_r;

endmodule : iep_prioritizer

// >>> test/iep_prioritizer_monitor.sv
// Checker for the offer and pending behaviour of the event prioritizer.
`timescale 1ns/1ps
module iep_prioritizer_monitor
  import iep_pkg::*;
#(
  parameter int EVENT_COUNT = IEP_EVENT_COUNT,
  parameter int DIN_COUNT = IEP_DIN_COUNT
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire iep_sources_t sources,
  input wire logic [DIN_COUNT-1:0] digital_in,
  input wire logic [EVENT_COUNT-1:0] event_enable,
  input wire logic global_enable,
  input wire logic flush,
  input wire logic [EVENT_COUNT-1:0] overrun_clear,
  input wire logic irq_valid,
  input wire logic irq_ack,
  input wire iep_entry_t irq_grant,
  input wire logic [EVENT_COUNT-1:0] pending,
  input wire logic [EVENT_COUNT-1:0] overrun
);
  localparam logic [33:0] COMM_M = 34'h007800300;
  localparam logic [33:0] TIMED_M = 34'h000600c00;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_stand;
    irq_valid && !irq_ack && !flush |=> irq_valid && $stable(irq_grant);
  endproperty
  property p_ack_drop;
    irq_valid && irq_ack |=> !irq_valid;
  endproperty
  property p_pend_match;
    irq_valid |-> pending[irq_grant.number];
  endproperty
  // The winner is chosen from the flags seen in the idle cycle before the offer.
  property p_comm_first;
    $rose(irq_valid) && irq_grant.group != IEP_GRP_COMM |-> ($past(pending) & COMM_M) == '0;
  endproperty
  property p_timed_last;
    $rose(irq_valid) && irq_grant.group == IEP_GRP_TIMED |-> ($past(pending) & ~TIMED_M) == '0;
  endproperty
  property p_rank_last;
    irq_valid && irq_grant.number == IEP_EV_TMR_B_DONE
      |-> irq_grant.group == IEP_GRP_TIMED && irq_grant.rank == 5'h03;
  endproperty
  property p_pend_rise;
    sources.periodic[0] && event_enable[10] && !flush |=> pending[10];
  endproperty
  property p_offer;
    !irq_valid && (|pending) && global_enable && !flush |=> irq_valid;
  endproperty

  a_stand: assert property (p_stand) else $error("offer changed before ack");
  a_ack_drop: assert property (p_ack_drop) else $error("offer kept after ack");
  a_pend_match: assert property (p_pend_match) else $error("offer not pending");
  a_comm_first: assert property (p_comm_first) else $error("comm event passed over");
  a_timed_last: assert property (p_timed_last) else $error("timed beat higher group");
  a_rank_last: assert property (p_rank_last) else $error("timer b entry wrong");
  a_pend_rise: assert property (p_pend_rise) else $error("periodic 0 not latched");
  a_offer: assert property (p_offer) else $error("pending event not offered");

  c_ack: cover property (irq_valid && irq_ack);
  c_timed: cover property (irq_valid && irq_grant.group == IEP_GRP_TIMED);
  c_overrun: cover property (|overrun);
endmodule : iep_prioritizer_monitor

bind iep_prioritizer iep_prioritizer_monitor #(.EVENT_COUNT(EVENT_COUNT), .DIN_COUNT(DIN_COUNT))
  u_mon (.clk(clk), .resetn(resetn), .sources(sources), .digital_in(digital_in),
  .event_enable(event_enable), .global_enable(global_enable), .flush(flush),
  .overrun_clear(overrun_clear), .irq_valid(irq_valid), .irq_ack(irq_ack),
  .irq_grant(irq_grant), .pending(pending), .overrun(overrun));

// >>> test/iep_src_model.sv
// Behavioural model of the event sources around the prioritizer.
`timescale 1ns/1ps
module iep_src_model
  import iep_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire iep_sources_t req,
  input wire logic [3:0] lag,
  output iep_sources_t sources
);
  iep_sources_t held_r;
  logic [3:0] wait_r;

  // A request waits lag cycles, then shows as a one-cycle pulse like a real source.
  always_ff @(posedge clk)
  begin
    if (!resetn || req != '0)
    begin
      held_r <= req;
      wait_r <= lag;
      sources <= '0;
    end
    else if (wait_r != 4'h0)
    begin
      wait_r <= wait_r - 4'h1;
      sources <= '0;
    end
    else
    begin
      sources <= held_r;
      held_r <= '0;
    end
  end
endmodule : iep_src_model

// >>> test/test_interrupt_event_prioritizer.sv
// Self-checking testbench of the interrupt event prioritizer.
`timescale 1ns/1ps
module test_interrupt_event_prioritizer
  import iep_pkg::*;
;
  localparam logic [5:0] ORD [34] = '{6'h08, 6'h09, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h13,
    6'h14, 6'h00, 6'h02, 6'h04, 6'h06, 6'h01, 6'h03, 6'h05, 6'h07, 6'h0c, 6'h1b, 6'h1c,
    6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h20, 6'h1d, 6'h1e, 6'h1f, 6'h21, 6'h0a,
    6'h0b, 6'h15, 6'h16};
  logic clk, resetn, gen, flush, valid, ack;
  logic [3:0] lag, din;
  logic [33:0] en, ovc, pending, overrun;
  iep_sources_t req, src;
  iep_entry_t grant;
  int n_errors, n_tests;

  iep_src_model u_src (.clk(clk), .resetn(resetn), .req(req), .lag(lag), .sources(src));
  iep_prioritizer dut (.clk(clk), .resetn(resetn), .sources(src), .digital_in(din),
    .event_enable(en), .global_enable(gen), .flush(flush), .overrun_clear(ovc),
    .irq_valid(valid), .irq_ack(ack), .irq_grant(grant), .pending(pending),
    .overrun(overrun));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test();
    $display("Errors: %0d, comparisons: %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic check_grant(iep_entry_t got, iep_entry_t exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t grant %h expected %h", $time, got, exp);
    end
  endtask : check_grant

  task automatic check_flags(logic [33:0] got, logic [33:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t flags %h expected %h", $time, got, exp);
    end
  endtask : check_flags

  task automatic check_valid(logic got, logic exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t valid %h expected %h", $time, got, exp);
    end
  endtask : check_valid

  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic fire(iep_sources_t s);
    @(posedge clk) req <= s;
    @(posedge clk) req <= '0;
  endtask : fire

  task automatic take(iep_entry_t exp);
    int k;
    k = 0;
    // Step off the edge so the previous acknowledge has already retired the offer.
    #1;
    while (valid !== 1'b1 && k < 40)
    begin
      tick(1);
      k++;
    end
    check_valid(valid, 1'b1);
    check_grant(grant, exp);
    @(posedge clk) ack <= 1'b1;
    @(posedge clk) ack <= 1'b0;
  endtask : take

  // Everything is raised while offers are held off, so the whole order shows at once.
  task automatic t_full_order();
    iep_entry_t e;
    @(posedge clk) din <= 4'hf;
    fire('1);
    din <= 4'h0;
    tick(4);
    check_flags(pending, '1);
    @(posedge clk) gen <= 1'b1;
    for (int i = 0; i < 34; i++)
    begin
      e.number = ORD[i];
      e.group = i < 6 ? IEP_GRP_COMM : (i < 30 ? IEP_GRP_DISCRETE : IEP_GRP_TIMED);
      e.rank = 5'(i < 3 ? 0 : (i < 6 ? 1 : (i < 30 ? i - 6 : i - 30)));
      take(e);
    end
    tick(2);
    check_flags(pending, '0);
  endtask : t_full_order

  task automatic t_drop_overrun();
    iep_sources_t s;
    s = '0;
    s.periodic[0] = 1'b1;
    @(posedge clk) gen <= 1'b0;
    en[10] <= 1'b0;
    fire(s);
    tick(3);
    check_flags(pending, '0);
    @(posedge clk) en[10] <= 1'b1;
    fire(s);
    fire(s);
    tick(3);
    check_flags(pending, 34'h000000400);
    check_flags(overrun, 34'h000000400);
    @(posedge clk) ovc[10] <= 1'b1;
    @(posedge clk) flush <= 1'b1;
    ovc[10] <= 1'b0;
    @(posedge clk) flush <= 1'b0;
    tick(2);
    check_flags(pending | overrun, '0);
  endtask : t_drop_overrun

  // A slow source and a late high-priority event must not displace the standing offer.
  task automatic t_no_preempt();
    iep_sources_t s;
    s = '0;
    s.ms_delay_timer_b_done = 1'b1;
    @(posedge clk) lag <= 4'h3;
    gen <= 1'b1;
    fire(s);
    tick(8);
    s = '0;
    s.port0.rx_char = 1'b1;
    fire(s);
    tick(8);
    take('{IEP_EV_TMR_B_DONE, IEP_GRP_TIMED, 5'h03});
    take('{IEP_EV_P0_RX_CHAR, IEP_GRP_COMM, 5'h00});
  endtask : t_no_preempt

  // Reset during an offer drops it; a high input at release must not count as an edge.
  task automatic t_reset();
    iep_sources_t s;
    s = '0;
    s.port1.tx_done = 1'b1;
    @(posedge clk) lag <= 4'h0;
    fire(s);
    fire(s);
    tick(4);
    check_valid(valid, 1'b1);
    check_flags(overrun, 34'h004000000);
    @(posedge clk) resetn <= 1'b0;
    din <= 4'h5;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    tick(3);
    check_valid(valid, 1'b0);
    check_grant(grant, IEP_GRANT_RST);
    check_flags(pending | overrun, '0);
    @(posedge clk) din <= 4'h0;
    tick(2);
    check_flags(pending, 34'h000000022);
  endtask : t_reset

  initial
  begin
    #40000;
    n_errors++;
    stop_test();
  end

  initial
  begin
    n_errors = 0;
    n_tests = 0;
    resetn = 1'b0;
    req = '0;
    lag = 4'h0;
    din = 4'h0;
    en = '1;
    gen = 1'b0;
    flush = 1'b0;
    ovc = '0;
    ack = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    tick(2);
    t_full_order();
    t_drop_overrun();
    t_no_preempt();
    t_reset();
    stop_test();
  end
endmodule : test_interrupt_event_prioritizer
